// ===== pisosr_ctrl_model.sv
`timescale 1ns/1ps

// ==========================================================
// controller model: drives the load, clock, enable and data pins
module pisosr_ctrl_model (
  input wire logic core_clk, // system clock
  output logic parallel_load_n, // load pin, active low
  output logic shift_clock, // clock pin
  output logic shift_enable_n, // enable pin, active low
  output logic serial_in, // serial data pin
  output logic [7:0] parallel_in // parallel data pins
);
  logic swap_q = 1'b0; // enable pin acts as the clock
  logic clk_lvl_q = 1'b1; // level of the pin used as clock
  logic gate_lvl_q = 1'b1; // level of the pin used as enable

  // pin roles swap freely since the gate is a plain or
  assign shift_clock = swap_q ? gate_lvl_q : clk_lvl_q;
  assign shift_enable_n = swap_q ? clk_lvl_q : gate_lvl_q;

  initial begin
    parallel_load_n = 1'b1;
    serial_in = 1'b0;
    parallel_in = 8'h00;
  end

  // every level is held 4 cycles, above the filter minimum
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // role change only while both pins sit high
  task automatic set_swap(input logic s);
    swap_q <= s;
    step(1);
  endtask

  // load; with jiggle the gate is exercised while load is low
  task automatic load(input logic [7:0] d, input bit jiggle);
    parallel_in <= d;
    parallel_load_n <= 1'b0;
    step(4);
    if (jiggle) begin
      clk_lvl_q <= 1'b0;
      step(4);
      gate_lvl_q <= 1'b0;
      step(4);
      clk_lvl_q <= 1'b1;
      step(4);
      gate_lvl_q <= 1'b1;
      step(4);
    end
    parallel_load_n <= 1'b1;
    step(2);
    parallel_in <= ~d;
    step(2);
  endtask

  // pulse the clock with the gate closed
  task automatic idle_toggle(input int n);
    repeat (n) begin
      clk_lvl_q <= 1'b0;
      step(4);
      clk_lvl_q <= 1'b1;
      step(4);
    end
  endtask

  // open the gate: enable falls only while the clock is low
  task automatic open_gate();
    clk_lvl_q <= 1'b0;
    step(4);
    gate_lvl_q <= 1'b0;
    step(4);
  endtask

  // close the gate: enable rises only while the clock is high
  task automatic close_gate();
    gate_lvl_q <= 1'b1;
    step(4);
  endtask

  // one shift; data is disturbed once its hold has run out
  task automatic shift_one(input logic b);
    serial_in <= b;
    clk_lvl_q <= 1'b0;
    step(4);
    clk_lvl_q <= 1'b1;
    step(2);
    serial_in <= ~b;
    step(4);
  endtask
endmodule

// ===== pisosr_fifo.sv
`timescale 1ns/1ps

// ==========================================================
// small synchronous fifo; read word always comes from a register
module pisosr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic core_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic in_valid, // write request
  output logic in_ready_q, // space available
  input wire logic [W-1:0] in_data, // write word
  output logic out_valid_q, // read word present
  input wire logic out_ready, // reader takes word
  output logic [W-1:0] out_data_q // read word
);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  // pop refills the output register whenever it is empty or drained
  assign push = in_valid & in_ready_q;
  assign pop = (count_q != '0) & (~out_valid_q | out_ready);

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  // storage has no reset; only the pointers define its content
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready_q <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_d;
      in_ready_q <= (count_d != (AW+1)'(DEPTH));
    end
  end

  // output register, stalls while the reader holds off
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (pop) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem[rd_ptr_q];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end

endmodule

// ===== pisosr_pkg.sv
package pisosr_pkg;

  // ==========================================================
  // stage geometry
  localparam int STAGE_W = 8;
  localparam int LAST_STAGE = 7;
  localparam int BIT_CNT_W = 3;

  // ==========================================================
  // pin vector layout; every pin crosses into core_clk together
  localparam int PIN_W = 12;
  localparam int PIN_LOAD = 0;
  localparam int PIN_CLK = 1;
  localparam int PIN_EN = 2;
  localparam int PIN_SER = 3;
  localparam int PIN_PAR_LSB = 4;

  // idle pin levels: load released, clock and enable high (hold)
  localparam logic [PIN_W-1:0] PIN_IDLE = 12'h0007;

  // ==========================================================
  // stream buffer for the captured output words
  localparam int TAP_W = 8;
  localparam int TAP_DEPTH = 16;
  localparam int TAP_AW = 4;

  // ==========================================================
  // reset values of control state
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_RST = 3'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
  localparam logic [TAP_W-1:0] TAP_ACC_RST = 8'h00;

  // ==========================================================
  // controller ordering faults seen on the pins
  localparam int WARN_W = 3;
  localparam int WARN_EN_RISE = 0;
  localparam int WARN_LOAD_REL = 1;
  localparam int WARN_EN_FALL = 2;
  localparam logic [WARN_W-1:0] WARN_RST = 3'h0;

  // shift engine mode
  typedef enum logic [1:0] {
    PISOSR_LOADING,
    PISOSR_HOLDING,
    PISOSR_SHIFTING
  } pisosr_mode_t;

endpackage

// ===== pisosr_shift.sv
`timescale 1ns/1ps

module pisosr_shift (
  input wire logic core_clk, // 40 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic parallel_load_n, // pin: parallel load, active low
  input wire logic shift_clock, // pin: shift clock
  input wire logic shift_enable_n, // pin: clock enable, active low
  input wire logic serial_in, // pin: serial data input
  input wire logic [7:0] parallel_in, // pins: parallel data
  output logic serial_out_q, // true output of last stage
  output logic serial_out_n_q, // inverted output of last stage
  output logic [7:0] tap_data_q, // captured output byte
  output logic tap_valid_q, // captured byte present
  input wire logic tap_ready, // consumer takes byte
  output logic tap_room_q, // buffer can accept a byte
  output logic tap_overflow_q, // sticky: byte dropped, buffer full
  output logic [2:0] order_warn_q // sticky controller ordering faults
);

  // ==========================================================
  // pin synchronisers
  logic [pisosr_pkg::PIN_W-1:0] pins;
  logic [pisosr_pkg::PIN_W-1:0] sync1_q;
  logic [pisosr_pkg::PIN_W-1:0] sync2_q;
  logic [pisosr_pkg::PIN_W-1:0] sync3_q;
  logic [pisosr_pkg::PIN_W-1:0] pin_f_q;

  assign pins = {parallel_in, serial_in, shift_enable_n, shift_clock,
                 parallel_load_n};

  // four flops per pin; a level counts once flops two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < pisosr_pkg::PIN_W; gi++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          sync1_q[gi] <= pisosr_pkg::PIN_IDLE[gi];
          sync2_q[gi] <= pisosr_pkg::PIN_IDLE[gi];
          sync3_q[gi] <= pisosr_pkg::PIN_IDLE[gi];
          pin_f_q[gi] <= pisosr_pkg::PIN_IDLE[gi];
        end else begin
          sync1_q[gi] <= pins[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            pin_f_q[gi] <= sync3_q[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // gated clock decode
  // the gate is symmetric, so either pin may serve as clock
  function automatic logic gate_or(input logic a, input logic b);
    return a | b;
  endfunction

  function automatic logic rising(input logic was, input logic now);
    return ~was & now;
  endfunction

  logic load_f;
  logic clk_f;
  logic en_f;
  logic ser_f;
  logic [7:0] par_f;
  logic comb_clk;
  logic comb_prev_q;
  logic clk_prev_q;
  logic en_prev_q;
  logic load_prev_q;
  logic ser_prev_q;
  logic comb_rise;
  logic shift_ev;
  pisosr_pkg::pisosr_mode_t mode;

  assign load_f = pin_f_q[pisosr_pkg::PIN_LOAD];
  assign clk_f = pin_f_q[pisosr_pkg::PIN_CLK];
  assign en_f = pin_f_q[pisosr_pkg::PIN_EN];
  assign ser_f = pin_f_q[pisosr_pkg::PIN_SER];
  assign par_f = pin_f_q[pisosr_pkg::PIN_PAR_LSB +: pisosr_pkg::STAGE_W];
  assign comb_clk = gate_or(clk_f, en_f);
  assign comb_rise = rising(comb_prev_q, comb_clk);

  // previous pin levels: edge detection and the pre-edge data sample
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      comb_prev_q <= 1'b1;
      clk_prev_q <= 1'b1;
      en_prev_q <= 1'b1;
      load_prev_q <= 1'b1;
      ser_prev_q <= 1'b0;
    end else begin
      comb_prev_q <= comb_clk;
      clk_prev_q <= clk_f;
      en_prev_q <= en_f;
      load_prev_q <= load_f;
      ser_prev_q <= ser_f;
    end
  end

  // mode decode: load first, then edge, else hold
  always_comb begin
    if (!load_f) begin
      mode = pisosr_pkg::PISOSR_LOADING;
    end else if (comb_rise) begin
      mode = pisosr_pkg::PISOSR_SHIFTING;
    end else begin
      mode = pisosr_pkg::PISOSR_HOLDING;
    end
  end

  assign shift_ev = (mode == pisosr_pkg::PISOSR_SHIFTING);

  // ==========================================================
  // shift stages
  logic [7:0] stages_q;
  logic [7:0] stages_d;

  always_comb begin
    case (mode)
      pisosr_pkg::PISOSR_LOADING: begin
        stages_d = par_f;
      end
      pisosr_pkg::PISOSR_SHIFTING: begin
        stages_d = {stages_q[6:0], ser_prev_q};
      end
      pisosr_pkg::PISOSR_HOLDING: begin
        stages_d = stages_q;
      end
      default: begin
        stages_d = stages_q;
      end
    endcase
  end

  // no reset on purpose: content is undefined until load or shifts
  always_ff @(posedge core_clk) begin
    stages_q <= stages_d;
  end

  // set by the first load; stage checks only mean something after it
  logic stages_known_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stages_known_q <= 1'b0;
    end else if (mode == pisosr_pkg::PISOSR_LOADING) begin
      stages_known_q <= 1'b1;
    end
  end

  // outputs register the same next value, so they track the last stage
  always_ff @(posedge core_clk) begin
    serial_out_q <= stages_d[pisosr_pkg::LAST_STAGE];
    serial_out_n_q <= ~stages_d[pisosr_pkg::LAST_STAGE];
  end

  // ==========================================================
  // output byte capture into the stream buffer
  logic [pisosr_pkg::BIT_CNT_W-1:0] bit_cnt_q;
  logic [7:0] acc_q;
  logic push_q;
  logic [7:0] push_data_q;
  logic fifo_ready;

  // each shift retires the old last stage; a load restarts the byte
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bit_cnt_q <= pisosr_pkg::BIT_CNT_RST;
      acc_q <= pisosr_pkg::TAP_ACC_RST;
      push_q <= 1'b0;
      push_data_q <= pisosr_pkg::TAP_ACC_RST;
    end else begin
      push_q <= 1'b0;
      if (!load_f) begin
        bit_cnt_q <= pisosr_pkg::BIT_CNT_RST;
      end else if (shift_ev) begin
        acc_q <= {acc_q[6:0], stages_q[pisosr_pkg::LAST_STAGE]};
        bit_cnt_q <= bit_cnt_q + 1'b1;
        if (bit_cnt_q == pisosr_pkg::BIT_CNT_LAST) begin
          push_q <= 1'b1;
          push_data_q <= {acc_q[6:0], stages_q[pisosr_pkg::LAST_STAGE]};
        end
      end
    end
  end

  // a shift cannot wait, so a full buffer drops the byte and flags it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tap_overflow_q <= 1'b0;
    end else if (push_q && !fifo_ready) begin
      tap_overflow_q <= 1'b1;
    end
  end

  pisosr_fifo #(
    .W(pisosr_pkg::TAP_W),
    .DEPTH(pisosr_pkg::TAP_DEPTH),
    .AW(pisosr_pkg::TAP_AW)
  ) u_tap_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(push_q),
    .in_ready_q(fifo_ready),
    .in_data(push_data_q),
    .out_valid_q(tap_valid_q),
    .out_ready(tap_ready),
    .out_data_q(tap_data_q)
  );

  assign tap_room_q = fifo_ready;

  // ==========================================================
  // controller ordering monitor, reported as sticky warning bits
  logic en_rise_bad;
  logic load_rel_bad;
  logic en_fall_bad;

  // the device still obeys the gate; these only tell software why
  assign en_rise_bad = load_f & rising(en_prev_q, en_f) & ~clk_f;
  assign load_rel_bad = rising(load_prev_q, load_f) &
                        ~(clk_prev_q | en_prev_q);
  assign en_fall_bad = load_f & rising(en_f, en_prev_q) & clk_f;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      order_warn_q <= pisosr_pkg::WARN_RST;
    end else begin
      if (en_rise_bad) begin
        order_warn_q[pisosr_pkg::WARN_EN_RISE] <= 1'b1;
      end
      if (load_rel_bad) begin
        order_warn_q[pisosr_pkg::WARN_LOAD_REL] <= 1'b1;
      end
      if (en_fall_bad) begin
        order_warn_q[pisosr_pkg::WARN_EN_FALL] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // the first high cycle may still carry the edge, so look one later
  sequence s_enable_held;
    stages_known_q && load_f && en_f ##1 load_f && en_f;
  endsequence

  sequence s_eight_shifts;
    shift_ev && bit_cnt_q == pisosr_pkg::BIT_CNT_LAST;
  endsequence

  chk_load_copy: assert property (
    !load_f |=> stages_q == $past(par_f))
    else $error("stages do not follow parallel inputs during load");

  chk_load_wins: assert property (
    !load_f && comb_rise |-> !shift_ev ##1 stages_q == $past(par_f))
    else $error("clock edge acted while load was low");

  chk_shift_move: assert property (
    shift_ev |=> stages_q[7:1] == $past(stages_q[6:0]))
    else $error("stages did not move one place on shift");

  chk_serial_take: assert property (
    shift_ev |=> stages_q[0] == $past(ser_prev_q))
    else $error("first stage missed pre-edge serial level");

  chk_edge_only: assert property (
    load_f && !comb_rise |-> !shift_ev)
    else $error("shift without a rising combined clock");

  // a pin that stayed high blocks any rise of the other one
  chk_or_gate: assert property (
    load_f && ((en_f && en_prev_q) || (clk_f && clk_prev_q)) |-> !shift_ev)
    else $error("high gate pin failed to block edges");

  chk_enable_hold: assert property (
    s_enable_held |=> stages_q == $past(stages_q))
    else $error("stages changed while enable was high");

  chk_pin_swap: assert property (
    shift_ev == (load_f && !$past(clk_f | en_f) && (clk_f | en_f)))
    else $error("gate is not symmetric in clock and enable");

  chk_out_pair: assert property (
    stages_known_q |->
      serial_out_q == stages_q[7] && serial_out_n_q == !serial_out_q)
    else $error("outputs disagree with last stage");

  chk_cascade: assert property (
    shift_ev |=> serial_out_q == $past(stages_q[6]))
    else $error("true output did not advance for cascade");

  chk_byte_push: assert property (
    s_eight_shifts |=> push_q ##1 !push_q)
    else $error("eighth shift did not push one byte");

  chk_warn_rise: assert property (
    en_rise_bad |=> order_warn_q[pisosr_pkg::WARN_EN_RISE])
    else $error("enable rise fault not recorded");

endmodule

// ===== test_piso_shift_register_8bit.sv
`timescale 1ns/1ps

// ==========================================================
// bench: stimulus notes expected bytes, a monitor checks them
module test_piso_shift_register_8bit;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tap_ready = 1'b0;
  logic hold_ready = 1'b0;
  logic parallel_load_n, shift_clock, shift_enable_n, serial_in;
  logic [7:0] parallel_in;
  logic serial_out_q, serial_out_n_q, tap_valid_q, tap_room_q;
  logic tap_overflow_q;
  logic [7:0] tap_data_q;
  logic [2:0] order_warn_q;
  logic [7:0] stg;
  logic [7:0] exp_q[$];
  integer seed = 32'hc135_6e5e;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  pisosr_ctrl_model bfm (
    .core_clk(core_clk),
    .parallel_load_n(parallel_load_n),
    .shift_clock(shift_clock),
    .shift_enable_n(shift_enable_n),
    .serial_in(serial_in),
    .parallel_in(parallel_in)
  );

  pisosr_shift dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .parallel_load_n(parallel_load_n),
    .shift_clock(shift_clock),
    .shift_enable_n(shift_enable_n),
    .serial_in(serial_in),
    .parallel_in(parallel_in),
    .serial_out_q(serial_out_q),
    .serial_out_n_q(serial_out_n_q),
    .tap_data_q(tap_data_q),
    .tap_valid_q(tap_valid_q),
    .tap_ready(tap_ready),
    .tap_room_q(tap_room_q),
    .tap_overflow_q(tap_overflow_q),
    .order_warn_q(order_warn_q)
  );

  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // both outputs against the modelled last stage
  task automatic check_out(input string what);
    check({6'h00, serial_out_q, serial_out_n_q},
          {6'h00, stg[7], ~stg[7]}, what);
  endtask

  // load d, optionally exercise the blocked gate, then shift n bits
  task automatic send_byte(input logic [7:0] d, input bit jiggle,
                           input int n, input bit push);
    logic b;
    bfm.load(d, jiggle);
    stg = d;
    check_out("load");
    if (jiggle) begin
      bfm.idle_toggle(3);
      check_out("hold");
    end
    if (push) begin
      exp_q.push_back(d);
    end
    bfm.open_gate();
    check_out("gate open");
    for (int i = 0; i < n; i++) begin
      b = 1'($random(seed));
      bfm.shift_one(b);
      stg = {stg[6:0], b};
      check_out("shift");
    end
    bfm.close_gate();
  endtask

  // bounded wait until every noted byte has come out
  task automatic drain();
    int t;
    t = 0;
    while (exp_q.size() > 0 && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    check({7'h00, exp_q.size() == 0}, 8'h01, "drain");
  endtask

  // consumer: random stalls unless told to hold off
  always @(posedge core_clk) begin
    tap_ready <= hold_ready ? 1'b0 : 1'($random(seed));
  end

  // monitor: each taken byte against the oldest note
  always @(posedge core_clk) begin
    if (rst_n === 1'b1 && tap_valid_q === 1'b1 && tap_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("[FAIL] %0t byte with none expected", $time);
      end else begin
        check(tap_data_q, exp_q.pop_front(), "tap byte");
      end
    end
  end

  // a hang is cut short well above the expected run length
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("[FAIL] %0t run did not finish", $time);
      test_done();
    end
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    bfm.step(2);
    check({7'h00, tap_room_q}, 8'h01, "room after reset");
    for (int i = 0; i < 3; i++) begin
      send_byte(8'($random(seed)), 1'b0, 8, 1'b1);
    end
    send_byte(8'h80, 1'b0, 8, 1'b1);
    $display("test load_shift done");
    send_byte(8'($random(seed)), 1'b1, 8, 1'b1);
    send_byte(8'h7f, 1'b1, 8, 1'b1);
    $display("test load_priority done");
    check({5'h00, order_warn_q}, 8'h00, "warnings in plain roles");
    bfm.set_swap(1'b1);
    send_byte(8'($random(seed)), 1'b1, 8, 1'b1);
    send_byte(8'($random(seed)), 1'b0, 8, 1'b1);
    bfm.set_swap(1'b0);
    $display("test swapped_pins done");
    send_byte(8'($random(seed)), 1'b0, 3, 1'b0);
    send_byte(8'($random(seed)), 1'b0, 8, 1'b1);
    $display("test partial_byte done");
    drain();
    hold_ready <= 1'b1;
    for (int i = 0; i < 18; i++) begin
      send_byte(8'($random(seed)), 1'b0, 8, i < 17);
    end
    bfm.step(4);
    check({7'h00, tap_room_q}, 8'h00, "room when full");
    check({7'h00, tap_overflow_q}, 8'h01, "overflow flag");
    hold_ready <= 1'b0;
    drain();
    // swapped roles move the enable pin against a low or high clock pin
    check({5'h00, order_warn_q}, 8'h05, "ordering warnings");
    $display("test fill_drain done");
    test_done();
  end
endmodule
